//--- hw/sasr_pkg.sv
// Shared constants and state types for the SAR ADC serial readout link
package sasr_pkg;

  // -------------------------------------------------------------------
  // Sizes
  // -------------------------------------------------------------------
  localparam int RESULT_W   = 16;
  localparam int FIFO_DEPTH = 8;
  localparam int CAL_BURST  = 1024;
  localparam int CNT_W      = 11;

  // -------------------------------------------------------------------
  // Timing
  // -------------------------------------------------------------------
  localparam int CLK_NS        = 8;
  localparam int CAL_TIME_MS   = 500;
  localparam int CAL_CYC       = (CAL_TIME_MS * 1000000) / CLK_NS;
  localparam int APERTURE_NS   = 16;
  localparam int APERTURE_CYC  = (APERTURE_NS + CLK_NS - 1) / CLK_NS;
  localparam int CONV_TIME_NS  = 800;
  localparam int CONV_CYC      = (CONV_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOST_CONV_NS  = 1000;
  localparam int HOST_CONV_CYC = (HOST_CONV_NS + CLK_NS - 1) / CLK_NS;
  localparam int SCLK_PER_NS   = 64;
  localparam int SCLK_HALF     = SCLK_PER_NS / (2 * CLK_NS);
  localparam int CAL_GUARD_CYC = 16;

  // -------------------------------------------------------------------
  // State types
  // -------------------------------------------------------------------
  typedef enum logic [1:0] {
    DEV_ACQ  = 2'h0,
    DEV_CONV = 2'h1,
    DEV_DONE = 2'h3,
    DEV_CAL  = 2'h2
  } sasr_dev_state_t;

  typedef enum logic [2:0] {
    HST_IDLE  = 3'h0,
    HST_CONV  = 3'h1,
    HST_SHIFT = 3'h3,
    HST_BURST = 3'h2,
    HST_CALW  = 3'h6
  } sasr_host_state_t;

endpackage : sasr_pkg

//--- hw/sasr_link_if.sv
// Four-wire serial link between converter and host
`timescale 1ns/1ns
interface sasr_link_if;

  logic convert_select_n;
  logic serial_in;
  logic serial_clk;
  logic serial_out_d;
  logic serial_out_oe;
  logic serial_out;

  // Released line is held high by the external pull-up
  assign serial_out = serial_out_oe ? serial_out_d : 1'h1;

  modport device (
    input  convert_select_n,
    input  serial_in,
    input  serial_clk,
    output serial_out_d,
    output serial_out_oe
  );

  modport host (
    output convert_select_n,
    output serial_in,
    output serial_clk,
    input  serial_out
  );

endinterface : sasr_link_if

//--- hw/sasr_device.sv
// Converter end: conversion timing, calibration and serial result output
`timescale 1ns/1ns

// Function
// - Link is select, data in, data out, clock
// - Host holds serial input high always
// - Select line is chip select and start
// - Rising select edge starts a conversion
// - Started conversion completes whatever select does
// - Select low after conversion presents result
// - Result MSB first, changes on clock fall
// - Host samples data on clock fall
// - Release output after last bit or select high
// - Host sends 1024 clocks in acquisition to recalibrate; the last readout's clocks count toward the 1024
// - Clock burst starts internal self-calibration
// - Output driven low while calibrating, then released
// - Calibration lasts about 500 ms
// - Host sees calibration end by pulled-up line
// - Input held fixed aperture after select rise
// - Result is two's complement, sign first
// - Result saturates at positive and negative limits
module sasr_device #(
  parameter int RESULT_W     = sasr_pkg::RESULT_W,
  parameter int CAL_CYC      = sasr_pkg::CAL_CYC,
  parameter int CONV_CYC     = sasr_pkg::CONV_CYC,
  parameter int APERTURE_CYC = sasr_pkg::APERTURE_CYC
) (
  input  wire logic                  mclk_i,
  input  wire logic                  srst_i,
  input  wire logic signed [RESULT_W:0] analog_i,
  output logic                       converting_o,
  output logic                       calibrating_o,
  output logic                       sample_o,
  output logic [RESULT_W-1:0]        last_result_o,
  sasr_link_if.device                link
);

  localparam int TW = $clog2(CAL_CYC + 1);
  localparam int BW = $clog2(RESULT_W + 1);

  // -------------------------------------------------------------------
  // Pin synchronisers and edge detection
  // -------------------------------------------------------------------
  logic [1:0] sel_s;
  logic [1:0] clk_s;
  logic       sel_q;
  logic       clk_q;
  logic       sel_rise;
  logic       sclk_fall;

  // Serial input carries nothing; the host keeps it high
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      sel_s <= 2'h0;
      clk_s <= 2'h0;
      sel_q <= 1'h0;
      clk_q <= 1'h0;
    end else begin
      sel_s <= {sel_s[0], link.convert_select_n};
      clk_s <= {clk_s[0], link.serial_clk};
      sel_q <= sel_s[1];
      clk_q <= clk_s[1];
    end
  end

  assign sel_rise  = sel_s[1] & ~sel_q;
  assign sclk_fall = ~clk_s[1] & clk_q;

  // -------------------------------------------------------------------
  // Result coding
  // -------------------------------------------------------------------
  function automatic logic [RESULT_W-1:0] clamp(input logic signed [RESULT_W:0] v);
    logic [RESULT_W-1:0] r;
    r = v[RESULT_W-1:0];
    if (v[RESULT_W] != v[RESULT_W-1]) begin
      r = {v[RESULT_W], {(RESULT_W-1){~v[RESULT_W]}}};
    end
    return r;
  endfunction : clamp

  // -------------------------------------------------------------------
  // State machine
  // -------------------------------------------------------------------
  sasr_pkg::sasr_dev_state_t state;
  sasr_pkg::sasr_dev_state_t next_state;
  logic [TW-1:0]             timer;
  logic [sasr_pkg::CNT_W-1:0] cal_cnt;
  logic                      cal_hit;
  logic                      shifting;
  logic [BW-1:0]             bit_cnt;
  logic                      last_fall;

  assign cal_hit   = (cal_cnt == sasr_pkg::CNT_W'(sasr_pkg::CAL_BURST));
  assign last_fall = shifting & sclk_fall & (bit_cnt == BW'(RESULT_W - 1));

  always_comb begin
    next_state = state;
    unique case (state)
      sasr_pkg::DEV_ACQ: begin
        if (sel_rise) begin
          next_state = sasr_pkg::DEV_CONV;
        end else if (cal_hit) begin
          next_state = sasr_pkg::DEV_CAL;
        end
      end
      sasr_pkg::DEV_CONV: begin
        // Select is ignored until the conversion is over
        if (timer == TW'(CONV_CYC - 1)) begin
          next_state = sasr_pkg::DEV_DONE;
        end
      end
      sasr_pkg::DEV_DONE: begin
        if (sel_rise) begin
          next_state = sasr_pkg::DEV_CONV;
        end else if (cal_hit) begin
          next_state = sasr_pkg::DEV_CAL;
        end else if (last_fall || (shifting && sel_s[1])) begin
          next_state = sasr_pkg::DEV_ACQ;
        end
      end
      sasr_pkg::DEV_CAL: begin
        if (timer == TW'(CAL_CYC - 1)) begin
          next_state = sasr_pkg::DEV_ACQ;
        end
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      state <= sasr_pkg::DEV_ACQ;
    end else begin
      state <= next_state;
    end
  end

  // Phase timer restarts on every state change
  always_ff @(posedge mclk_i) begin
    if (srst_i || next_state != state) begin
      timer <= '0;
    end else begin
      timer <= timer + TW'(1);
    end
  end

  // -------------------------------------------------------------------
  // Recalibration burst counter
  // -------------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (srst_i || next_state == sasr_pkg::DEV_CONV || state == sasr_pkg::DEV_CAL) begin
      cal_cnt <= '0;
    end else if (sclk_fall && !cal_hit) begin
      cal_cnt <= cal_cnt + sasr_pkg::CNT_W'(1);
    end
  end

  // -------------------------------------------------------------------
  // Sampling
  // -------------------------------------------------------------------
  logic [RESULT_W-1:0] hold;

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      hold     <= '0;
      sample_o <= 1'h0;
    end else begin
      sample_o <= 1'h0;
      if (state == sasr_pkg::DEV_CONV && timer == TW'(APERTURE_CYC - 1)) begin
        hold     <= clamp(analog_i);
        sample_o <= 1'h1;
      end
    end
  end

  // -------------------------------------------------------------------
  // Serial output
  // -------------------------------------------------------------------
  logic [RESULT_W-1:0] shreg;

  always_ff @(posedge mclk_i) begin
    if (srst_i || state != sasr_pkg::DEV_DONE || next_state != sasr_pkg::DEV_DONE) begin
      shifting <= 1'h0;
      bit_cnt  <= '0;
    end else if (!shifting && !sel_s[1]) begin
      shifting <= 1'h1;
      bit_cnt  <= '0;
    end else if (shifting && sclk_fall) begin
      bit_cnt  <= bit_cnt + BW'(1);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      shreg <= '0;
    end else if (state == sasr_pkg::DEV_DONE && !shifting && !sel_s[1]) begin
      shreg <= hold;
    end else if (shifting && sclk_fall) begin
      shreg <= {shreg[RESULT_W-2:0], 1'h0};
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      link.serial_out_d  <= 1'h0;
      link.serial_out_oe <= 1'h0;
    end else if (next_state == sasr_pkg::DEV_CAL) begin
      link.serial_out_d  <= 1'h0;
      link.serial_out_oe <= 1'h1;
    end else if (next_state == sasr_pkg::DEV_DONE && !sel_s[1]) begin
      link.serial_out_d  <= shifting ? shreg[RESULT_W-1] : hold[RESULT_W-1];
      link.serial_out_oe <= 1'h1;
    end else begin
      link.serial_out_d  <= 1'h0;
      link.serial_out_oe <= 1'h0;
    end
  end

  // -------------------------------------------------------------------
  // User-side status
  // -------------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      converting_o  <= 1'h0;
      calibrating_o <= 1'h0;
      last_result_o <= '0;
    end else begin
      converting_o  <= (next_state == sasr_pkg::DEV_CONV);
      calibrating_o <= (next_state == sasr_pkg::DEV_CAL);
      if (state == sasr_pkg::DEV_CONV && next_state == sasr_pkg::DEV_DONE) begin
        last_result_o <= hold;
      end
    end
  end

endmodule : sasr_device

//--- hw/sasr_host.sv
// Host end: conversion control, readout, recalibration and result FIFO
`timescale 1ns/1ns

// -------------------------------------------------------------------
// Result FIFO
// -------------------------------------------------------------------
module sasr_fifo #(
  parameter int WIDTH = sasr_pkg::RESULT_W,
  parameter int DEPTH = sasr_pkg::FIFO_DEPTH
) (
  input  wire logic             mclk_i,
  input  wire logic             srst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wptr;
  logic [AW-1:0]    rptr;
  logic [CW-1:0]    count;
  logic             push;
  logic             pop;

  assign in_ready_o  = (count != CW'(DEPTH));
  assign out_valid_o = (count != '0);
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;
  assign out_data_o  = mem[rptr];

  always_ff @(posedge mclk_i) begin
    if (push) begin
      mem[wptr] <= in_data_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      wptr  <= '0;
      rptr  <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wptr <= (wptr == AW'(DEPTH - 1)) ? '0 : wptr + AW'(1);
      end
      if (pop) begin
        rptr <= (rptr == AW'(DEPTH - 1)) ? '0 : rptr + AW'(1);
      end
      count <= count + CW'(push) - CW'(pop);
    end
  end

endmodule : sasr_fifo

// -------------------------------------------------------------------
// Host controller
// -------------------------------------------------------------------
module sasr_host #(
  parameter int RESULT_W      = sasr_pkg::RESULT_W,
  parameter int HOST_CONV_CYC = sasr_pkg::HOST_CONV_CYC,
  parameter int FIFO_DEPTH    = sasr_pkg::FIFO_DEPTH
) (
  input  wire logic          mclk_i,
  input  wire logic          srst_i,
  input  wire logic          start_i,
  input  wire logic          cal_i,
  output logic [RESULT_W-1:0] result_data_o,
  output logic               result_valid_o,
  input  wire logic          result_ready_i,
  output logic               busy_o,
  output logic               calibrating_o,
  sasr_link_if.host          link
);

  localparam int TW = 16;

  logic [1:0]                 so_s;
  sasr_pkg::sasr_host_state_t state;
  logic [TW-1:0]              timer;
  logic                       sclk;
  logic                       sel;
  logic [sasr_pkg::CNT_W-1:0] falls;
  logic [RESULT_W-1:0]        shreg;
  logic                       push;
  logic                       fifo_ready;
  logic                       half_tick;
  logic                       fall;

  assign link.serial_in        = 1'h1;
  assign link.serial_clk       = sclk;
  assign link.convert_select_n = sel;
  assign half_tick = (timer == TW'(sasr_pkg::SCLK_HALF - 1));
  assign fall      = half_tick & sclk;
  assign busy_o        = (state != sasr_pkg::HST_IDLE);
  assign calibrating_o = (state == sasr_pkg::HST_BURST) | (state == sasr_pkg::HST_CALW);

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      so_s <= 2'h3;
    end else begin
      so_s <= {so_s[0], link.serial_out};
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      state <= sasr_pkg::HST_IDLE;
      timer <= '0;
      sclk  <= 1'h0;
      sel   <= 1'h0;
      falls <= '0;
      shreg <= '0;
      push  <= 1'h0;
    end else begin
      push  <= 1'h0;
      timer <= timer + TW'(1);
      unique case (state)
        sasr_pkg::HST_IDLE: begin
          timer <= '0;
          // Burst count keeps the last readout's clocks
          // A full FIFO holds off the next conversion
          if (start_i && fifo_ready) begin
            falls <= '0;
            sel   <= 1'h1;
            state <= sasr_pkg::HST_CONV;
          end else if (cal_i) begin
            state <= sasr_pkg::HST_BURST;
          end
        end
        sasr_pkg::HST_CONV: begin
          if (timer == TW'(HOST_CONV_CYC - 1)) begin
            sel   <= 1'h0;
            timer <= '0;
            state <= sasr_pkg::HST_SHIFT;
          end
        end
        sasr_pkg::HST_SHIFT, sasr_pkg::HST_BURST: begin
          if (half_tick) begin
            timer <= '0;
            sclk  <= ~sclk;
          end
          if (fall) begin
            falls <= falls + sasr_pkg::CNT_W'(1);
            shreg <= {shreg[RESULT_W-2:0], so_s[1]};
          end
          if (state == sasr_pkg::HST_SHIFT && fall
              && falls == sasr_pkg::CNT_W'(RESULT_W - 1)) begin
            push  <= 1'h1;
            state <= sasr_pkg::HST_IDLE;
          end
          if (state == sasr_pkg::HST_BURST && fall
              && falls == sasr_pkg::CNT_W'(sasr_pkg::CAL_BURST - 1)) begin
            timer <= '0;
            falls <= '0;
            state <= sasr_pkg::HST_CALW;
          end
        end
        sasr_pkg::HST_CALW: begin
          // Guard lets the device pull the line low before watching it
          if (timer >= TW'(sasr_pkg::CAL_GUARD_CYC)) begin
            timer <= TW'(sasr_pkg::CAL_GUARD_CYC);
            if (so_s[1]) begin
              state <= sasr_pkg::HST_IDLE;
            end
          end
        end
        default: begin
          state <= sasr_pkg::HST_IDLE;
        end
      endcase
    end
  end

  sasr_fifo #(
    .WIDTH (RESULT_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk_i      (mclk_i),
    .srst_i      (srst_i),
    .in_valid_i  (push),
    .in_ready_o  (fifo_ready),
    .in_data_i   (shreg),
    .out_valid_o (result_valid_o),
    .out_ready_i (result_ready_i),
    .out_data_o  (result_data_o)
  );

endmodule : sasr_host

//--- tb/sasr_checker.sv
// Checker for timing relations on the converter link wires
`timescale 1ns/1ns
module sasr_checker #(
  parameter int RESULT_W      = sasr_pkg::RESULT_W,
  parameter int CAL_CYC       = sasr_pkg::CAL_CYC,
  parameter int HOST_CONV_CYC = sasr_pkg::HOST_CONV_CYC
) (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic convert_select_n,
  input wire logic serial_in,
  input wire logic serial_clk,
  input wire logic serial_out_d,
  input wire logic serial_out_oe,
  input wire logic serial_out
);
  // -------------------------------------------------------------------
  // Helper counters
  // -------------------------------------------------------------------
  logic        sclk_q;
  logic        oe_q;
  logic        sclk_fall;
  logic        in_cal;
  logic [11:0] fall_cnt;
  logic [11:0] rd_falls;
  logic [3:0]  fall_age;
  logic [15:0] hi_run;
  logic [31:0] cal_run;

  assign sclk_fall = sclk_q & ~serial_clk;

  always_ff @(posedge mclk_i) begin
    sclk_q <= serial_clk;
    oe_q   <= serial_out_oe;
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i || $rose(convert_select_n)) fall_cnt <= '0;
    else if (sclk_fall && fall_cnt != 12'hfff) fall_cnt <= fall_cnt + 12'h001;
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i || $fell(convert_select_n)) rd_falls <= '0;
    else if (sclk_fall && rd_falls != 12'hfff) rd_falls <= rd_falls + 12'h001;
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i || sclk_fall) fall_age <= '0;
    else if (fall_age != 4'hf) fall_age <= fall_age + 4'h1;
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i || !convert_select_n) hi_run <= '0;
    else if (hi_run != 16'hffff) hi_run <= hi_run + 16'h0001;
  end

  // Calibration window from the last burst clock to the line release
  always_ff @(posedge mclk_i) begin
    if (srst_i) in_cal <= 1'b0;
    else if (sclk_fall && fall_cnt == 12'(sasr_pkg::CAL_BURST - 1)) in_cal <= 1'b1;
    else if (oe_q && !serial_out_oe) in_cal <= 1'b0;
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i || !in_cal) cal_run <= '0;
    else cal_run <= cal_run + 32'h1;
  end

  // -------------------------------------------------------------------
  // Properties
  // -------------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);

  property p_sdi_high;
    serial_in;
  endproperty
  a_sdi_high: assert property (p_sdi_high)
    else $error("serial input not high");

  property p_no_drive_conv;
    $rose(convert_select_n) |-> ##6 (!serial_out_oe)[*8];
  endproperty
  a_no_drive_conv: assert property (p_no_drive_conv)
    else $error("output driven during conversion");

  property p_sel_release;
    $rose(convert_select_n) |-> ##[1:6] !serial_out_oe;
  endproperty
  a_sel_release: assert property (p_sel_release)
    else $error("output not released on select high");

  property p_present;
    $fell(convert_select_n) |-> ##[1:6] serial_out_oe;
  endproperty
  a_present: assert property (p_present)
    else $error("result not presented on select low");

  property p_last_release;
    sclk_fall && rd_falls == 12'(RESULT_W - 1) && !convert_select_n |-> ##[1:6] !serial_out_oe;
  endproperty
  a_last_release: assert property (p_last_release)
    else $error("output not released after last bit");

  property p_shift_on_fall;
    serial_out_oe && $past(serial_out_oe) && $changed(serial_out_d) |-> fall_age <= 4'h5;
  endproperty
  a_shift_on_fall: assert property (p_shift_on_fall)
    else $error("data changed away from clock fall");

  property p_cal_start;
    sclk_fall && fall_cnt == 12'(sasr_pkg::CAL_BURST - 1) |-> ##[1:8] (serial_out_oe && !serial_out_d);
  endproperty
  a_cal_start: assert property (p_cal_start)
    else $error("burst did not start calibration");

  property p_cal_low;
    in_cal && serial_out_oe |-> !serial_out_d;
  endproperty
  a_cal_low: assert property (p_cal_low)
    else $error("line not low while calibrating");

  property p_cal_len;
    in_cal && $fell(serial_out_oe) |-> cal_run >= 32'(CAL_CYC - 2) && cal_run <= 32'(CAL_CYC + 10);
  endproperty
  a_cal_len: assert property (p_cal_len)
    else $error("calibration length wrong");

  property p_sclk_quiet;
    convert_select_n |-> !$fell(serial_clk);
  endproperty
  a_sclk_quiet: assert property (p_sclk_quiet)
    else $error("serial clock during conversion");

  property p_conv_wait;
    $fell(convert_select_n) |-> hi_run >= 16'(HOST_CONV_CYC - 1) && hi_run <= 16'(HOST_CONV_CYC + 1);
  endproperty
  a_conv_wait: assert property (p_conv_wait)
    else $error("select lowered at wrong time");
endmodule : sasr_checker

//--- tb/test_sar_adc_serial_readout.sv
// Bench joining host and converter ends, checked against a queue model
`timescale 1ns/1ns
module test_sar_adc_serial_readout;
  localparam int RW  = sasr_pkg::RESULT_W;
  localparam int CAL = 200;

  logic                 mclk_i;
  logic                 srst_i;
  logic signed [RW:0]   analog_i;
  logic                 start_i;
  logic                 cal_i;
  logic                 result_ready_i;
  logic [RW-1:0]        result_data_o;
  logic                 result_valid_o;
  logic                 busy_o;
  logic                 host_cal_o;
  logic                 dev_cal_o;
  logic                 dev_conv_o;
  logic                 dev_sample_o;
  logic [RW-1:0]        last_result_o;
  int                   fail_count;
  int                   n_checks;
  int                   n_samples = 0;
  int                   seed_v;
  int                   r;
  logic [RW-1:0]        model_q[$];
  logic signed [RW:0]   corner[8] = '{17'h0ffff, 17'h08000, 17'h07fff, 17'h00000,
                                      17'h1ffff, 17'h18000, 17'h17fff, 17'h10000};

  sasr_link_if sasr_link_if_i ();

  sasr_device #(.CAL_CYC(CAL)) sasr_device_i (
    .mclk_i(mclk_i), .srst_i(srst_i), .analog_i(analog_i), .converting_o(dev_conv_o),
    .calibrating_o(dev_cal_o), .sample_o(dev_sample_o), .last_result_o(last_result_o),
    .link(sasr_link_if_i));

  sasr_host sasr_host_i (
    .mclk_i(mclk_i), .srst_i(srst_i), .start_i(start_i), .cal_i(cal_i),
    .result_data_o(result_data_o), .result_valid_o(result_valid_o),
    .result_ready_i(result_ready_i), .busy_o(busy_o), .calibrating_o(host_cal_o),
    .link(sasr_link_if_i));

  sasr_checker #(.CAL_CYC(CAL)) sasr_checker_i (
    .mclk_i(mclk_i), .srst_i(srst_i),
    .convert_select_n(sasr_link_if_i.convert_select_n),
    .serial_in(sasr_link_if_i.serial_in), .serial_clk(sasr_link_if_i.serial_clk),
    .serial_out_d(sasr_link_if_i.serial_out_d),
    .serial_out_oe(sasr_link_if_i.serial_out_oe), .serial_out(sasr_link_if_i.serial_out));

  // -------------------------------------------------------------------
  // Tasks
  // -------------------------------------------------------------------
  task automatic check(input string what, input logic [RW-1:0] seen, input logic [RW-1:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  function automatic logic [RW-1:0] sat(input int v);
    int hi;
    hi = (1 <<< (RW - 1)) - 1;
    if (v > hi) return hi[RW-1:0];
    if (v < -hi - 1) return {1'b1, {(RW-1){1'b0}}};
    return v[RW-1:0];
  endfunction : sat

  function automatic bit cond(input int sel);
    case (sel)
      0: return busy_o === 1'b0;
      1: return result_valid_o === 1'b1;
      2: return sasr_link_if_i.convert_select_n === 1'b0 && sasr_link_if_i.serial_out_oe === 1'b1;
      3: return dev_cal_o === 1'b1;
      default: return host_cal_o === 1'b0;
    endcase
  endfunction : cond

  task automatic wait_cond(input int sel, input int lim);
    int n;
    n = 0;
    while (!cond(sel) && n < lim) begin
      @(negedge mclk_i);
      n++;
    end
    if (!cond(sel)) begin
      fail_count++;
      $display("Error wait %0d expected 1 seen 0", sel);
    end
  endtask : wait_cond

  task automatic do_conv(input logic signed [RW:0] a);
    logic [RW-1:0] e;
    int            ns;
    e = sat(int'(a));
    wait_cond(0, 400);
    ns = n_samples;
    @(posedge mclk_i);
    analog_i <= a;
    start_i  <= 1'b1;
    @(posedge mclk_i);
    start_i  <= 1'b0;
    model_q.push_back(e);
    repeat (20) @(negedge mclk_i);
    check("converting", RW'(dev_conv_o), RW'(1));
    wait_cond(2, 300);
    check("msb", RW'(sasr_link_if_i.serial_out), RW'(e[RW-1]));
    wait_cond(0, 400);
    check("last", last_result_o, e);
    check("samples", RW'(n_samples - ns), RW'(1));
  endtask : do_conv

  task automatic drain();
    while (model_q.size() > 0) begin
      wait_cond(1, 50);
      check("word", result_data_o, model_q.pop_front());
      @(posedge mclk_i);
      result_ready_i <= 1'b1;
      @(posedge mclk_i);
      result_ready_i <= 1'b0;
      @(negedge mclk_i);
    end
    check("empty", RW'(result_valid_o), '0);
  endtask : drain

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out

  // -------------------------------------------------------------------
  // Sequence
  // -------------------------------------------------------------------
  initial begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
  end

  // One capture pulse per conversion
  always @(posedge mclk_i) begin
    if (dev_sample_o === 1'b1) begin
      n_samples <= n_samples + 1;
    end
  end

  initial begin
    repeat (40000) @(posedge mclk_i);
    fail_count++;
    $display("Error watchdog expected done seen hang");
    close_out();
  end

  initial begin
    srst_i = 1'b1;
    analog_i = '0;
    start_i = 1'b0;
    cal_i = 1'b0;
    result_ready_i = 1'b0;
    fail_count = 0;
    n_checks = 0;
    seed_v = $urandom(26);
    repeat (3) @(posedge mclk_i);
    srst_i <= 1'b0;
    @(negedge mclk_i);
    check("idle_line", RW'(sasr_link_if_i.serial_out), RW'(1));
    check("sdi", RW'(sasr_link_if_i.serial_in), RW'(1));
    foreach (corner[i]) begin
      do_conv(corner[i]);
      drain();
    end
    repeat (6) begin
      r = int'($urandom_range(0, (1 << RW) - 1)) - (1 << (RW - 1));
      do_conv(r[RW:0]);
      drain();
    end
    // Fill the result buffer, then a start must be refused
    repeat (sasr_pkg::FIFO_DEPTH) begin
      r = int'($urandom_range(0, (1 << (RW + 1)) - 1)) - (1 << RW);
      do_conv(r[RW:0]);
    end
    @(posedge mclk_i);
    start_i <= 1'b1;
    @(posedge mclk_i);
    start_i <= 1'b0;
    repeat (4) @(negedge mclk_i);
    check("full_busy", RW'(busy_o), '0);
    check("full_sel", RW'(sasr_link_if_i.convert_select_n), '0);
    drain();
    // Recalibration burst
    @(posedge mclk_i);
    cal_i <= 1'b1;
    @(posedge mclk_i);
    cal_i <= 1'b0;
    wait_cond(3, 9000);
    @(negedge mclk_i);
    check("cal_line", RW'(sasr_link_if_i.serial_out), '0);
    wait_cond(4, 1000);
    check("cal_done", RW'(dev_cal_o), '0);
    check("cal_end_line", RW'(sasr_link_if_i.serial_out), RW'(1));
    // Reset in the middle of a readout
    @(posedge mclk_i);
    start_i <= 1'b1;
    @(posedge mclk_i);
    start_i <= 1'b0;
    repeat (140) @(posedge mclk_i);
    srst_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    srst_i <= 1'b0;
    @(negedge mclk_i);
    check("rst_line", RW'(sasr_link_if_i.serial_out), RW'(1));
    check("rst_valid", RW'(result_valid_o), '0);
    do_conv(corner[5]);
    drain();
    close_out();
  end
endmodule : test_sar_adc_serial_readout
